// ==== verilog/rcpm_ctrl.v ====
// Design decision made here: the APB interface to the registers.
`include "rcpm_map.vh"
`timescale 1ns/100ps
`default_nettype none
module rcpm_ctrl #(
	parameter ADDR_W = 14
) (
	input wire sys_clk,
	input wire nrst,
	input wire por_event,
	input wire pin_reset_event,
	input wire [ADDR_W-1:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire seq_wr,
	input wire seq_sleep_cmd,
	input wire timer_sleep_req,
	input wire wake_req,
	output reg soft_reset_req,
	output reg hs_clk_enable,
	output reg digital_core_power,
	output reg sram_power,
	output reg ram_keep_in_sleep,
	output reg adc_switch_on,
	output reg lf_sysclk_allowed,
	output reg [31:0] lowpower_powerdown
);

// ----------------------------------------
// Bus decode
// ----------------------------------------
wire wr_acc = psel & penable & pwrite;
wire rd_acc = psel & penable & ~pwrite;
assign pready = 1'b1;

function is_addr;
	input [ADDR_W-1:0] a;
	input [ADDR_W-1:0] b;
	begin
		is_addr = (a == b);
	end
endfunction

wire hit_ctrl = is_addr(paddr, `RCPM_ADDR_POWER_MODE_CTRL);
wire hit_pkey = is_addr(paddr, `RCPM_ADDR_POWER_MODE_KEY);
wire hit_stat = is_addr(paddr, `RCPM_ADDR_RESET_CAUSE_STATUS);
wire hit_swrst = is_addr(paddr, `RCPM_ADDR_SOFT_RESET_TRIGGER);
wire hit_lkey = is_addr(paddr, `RCPM_ADDR_LOWPOWER_UNLOCK_KEY);
wire hit_lclk = is_addr(paddr, `RCPM_ADDR_LOWPOWER_CLOCK_SELECT);
wire hit_lcon = is_addr(paddr, `RCPM_ADDR_LOWPOWER_BLOCK_POWERDOWN);
wire hit_sys = is_addr(paddr, `RCPM_ADDR_SYS_STATUS);
wire hit_any = hit_ctrl | hit_pkey | hit_stat | hit_swrst | hit_lkey | hit_lclk | hit_lcon | hit_sys;
assign pslverr = psel & penable & ~hit_any;

// ----------------------------------------
// Registers
// ----------------------------------------
reg [15:0] power_mode_ctrl_reg;
reg [15:0] power_mode_key_reg;
reg [1:0] pkey_state_reg;
reg [3:0] reset_cause_status_reg;
reg [19:0] lowpower_unlock_key_reg;
reg lowpower_clock_select_reg;
reg [31:0] lowpower_block_powerdown_reg;
reg [1:0] actual_mode_reg;
reg asleep_reg;
reg por_seen_reg;

localparam PK_LOCKED = 2'h0;
localparam PK_FIRST = 2'h1;
localparam PK_OPEN = 2'h2;

wire lp_unlocked = (lowpower_unlock_key_reg == `RCPM_LP_KEY);
wire soft_trig = wr_acc & hit_swrst & (pwdata[15:0] == `RCPM_SOFT_RESET_CODE);
// Any write to the trigger register marks the cause flag
wire soft_flag_set = wr_acc & hit_swrst;

// ----------------------------------------
// Power mode key sequence
// ----------------------------------------
always @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		pkey_state_reg <= PK_LOCKED;
		power_mode_key_reg <= 16'h0000;
	end else if (wr_acc) begin
		if (hit_pkey) begin
			power_mode_key_reg <= pwdata[15:0];
			case (pkey_state_reg)
				PK_LOCKED: begin
					pkey_state_reg <= (pwdata[15:0] == `RCPM_PWR_KEY_FIRST) ? PK_FIRST : PK_LOCKED;
				end
				PK_FIRST: begin
					pkey_state_reg <= (pwdata[15:0] == `RCPM_PWR_KEY_SECOND) ? PK_OPEN : PK_LOCKED;
				end
				default: begin
					pkey_state_reg <= (pwdata[15:0] == `RCPM_PWR_KEY_FIRST) ? PK_FIRST : PK_LOCKED;
				end
			endcase
		end else begin
			pkey_state_reg <= PK_LOCKED;
		end
	end
end

// ----------------------------------------
// Power mode control
// ----------------------------------------
always @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		power_mode_ctrl_reg <= `RCPM_RST_POWER_MODE_CTRL;
		actual_mode_reg <= `RCPM_MODE_ACTIVE;
	end else if (wr_acc && hit_ctrl && pkey_state_reg == PK_OPEN) begin
		power_mode_ctrl_reg <= pwdata[15:0] & 16'hC00F;
		if (pwdata[1:0] != `RCPM_MODE_RESERVED && pwdata[1:0] != 2'h0)
			actual_mode_reg <= pwdata[1:0];
	end else if (actual_mode_reg == `RCPM_MODE_HIBERNATE && wake_req) begin
		actual_mode_reg <= `RCPM_MODE_ACTIVE;
	end
end

// Autosleep from sequencer command or wake-up timer
always @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		asleep_reg <= 1'b0;
	end else if (wake_req) begin
		asleep_reg <= 1'b0;
	end else if ((seq_sleep_cmd & power_mode_ctrl_reg[`RCPM_BIT_SEQ_SLEEP]) |
		(timer_sleep_req & power_mode_ctrl_reg[`RCPM_BIT_TIMER_SLEEP])) begin
		asleep_reg <= 1'b1;
	end
end

// ----------------------------------------
// Reset cause status
// ----------------------------------------
always @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		reset_cause_status_reg <= 4'h0;
		por_seen_reg <= 1'b0;
	end else begin
		por_seen_reg <= 1'b1;
		// Clear first, set afterwards so a new event wins
		if (wr_acc && hit_stat)
			reset_cause_status_reg <= (reset_cause_status_reg & ~pwdata[3:0])
				| {soft_flag_set, 1'b0, pin_reset_event, por_event | ~por_seen_reg};
		else
			reset_cause_status_reg <= reset_cause_status_reg
				| {soft_flag_set, 1'b0, pin_reset_event, por_event | ~por_seen_reg};
	end
end

// ----------------------------------------
// Low-power key, clock select, configuration
// ----------------------------------------
always @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		lowpower_unlock_key_reg <= 20'h00000;
		lowpower_clock_select_reg <= 1'b0;
		lowpower_block_powerdown_reg <= `RCPM_RST_LOWPOWER_BLOCK_POWERDOWN;
	end else if (wr_acc) begin
		if (hit_lkey)
			lowpower_unlock_key_reg <= pwdata[19:0];
		if (hit_lclk && lp_unlocked)
			lowpower_clock_select_reg <= pwdata[`RCPM_BIT_LF_SYSCLK];
		if (hit_lcon && lp_unlocked)
			lowpower_block_powerdown_reg <= pwdata & `RCPM_LPCON_MASK;
	end else if (seq_wr && lp_unlocked && hit_lclk) begin
		lowpower_clock_select_reg <= pwdata[`RCPM_BIT_LF_SYSCLK];
	end
end

// ----------------------------------------
// Power domain outputs
// ----------------------------------------
wire sleeping = (actual_mode_reg == `RCPM_MODE_HIBERNATE) | asleep_reg;
always @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		soft_reset_req <= 1'b0;
		hs_clk_enable <= 1'b1;
		digital_core_power <= 1'b1;
		sram_power <= 1'b1;
		ram_keep_in_sleep <= 1'b0;
		adc_switch_on <= 1'b1;
		lf_sysclk_allowed <= 1'b0;
		lowpower_powerdown <= `RCPM_RST_LOWPOWER_BLOCK_POWERDOWN;
	end else begin
		soft_reset_req <= soft_trig;
		hs_clk_enable <= ~sleeping & ~lowpower_block_powerdown_reg[`RCPM_BIT_HFOSC_PD];
		digital_core_power <= ~sleeping;
		sram_power <= ~sleeping | power_mode_ctrl_reg[`RCPM_BIT_RAM_KEEP];
		ram_keep_in_sleep <= power_mode_ctrl_reg[`RCPM_BIT_RAM_KEEP];
		adc_switch_on <= ~sleeping | power_mode_ctrl_reg[`RCPM_BIT_ADC_KEEP];
		lf_sysclk_allowed <= lowpower_clock_select_reg;
		lowpower_powerdown <= lowpower_block_powerdown_reg;
	end
end

// ----------------------------------------
// Read mux
// ----------------------------------------
always @* begin
	prdata = 32'h00000000;
	if (rd_acc) begin
		if (hit_ctrl)
			prdata = {16'h0000, power_mode_ctrl_reg};
		else if (hit_pkey)
			prdata = {16'h0000, power_mode_key_reg};
		else if (hit_stat)
			prdata = {28'h0000000, reset_cause_status_reg};
		else if (hit_lkey)
			prdata = {12'h000, lowpower_unlock_key_reg};
		else if (hit_lclk)
			prdata = {31'h00000000, lowpower_clock_select_reg};
		else if (hit_lcon)
			prdata = lowpower_block_powerdown_reg;
		else if (hit_sys)
			prdata = {28'h0000000, asleep_reg, pkey_state_reg == PK_OPEN, actual_mode_reg};
	end
end

endmodule
`default_nettype wire

// ==== verilog/rcpm_map.vh ====
`ifndef RCPM_MAP_VH
`define RCPM_MAP_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define RCPM_ADDR_POWER_MODE_CTRL 14'h0A00
`define RCPM_ADDR_POWER_MODE_KEY 14'h0A04
`define RCPM_ADDR_RESET_CAUSE_STATUS 14'h0A40
`define RCPM_ADDR_SOFT_RESET_TRIGGER 14'h0424
`define RCPM_ADDR_LOWPOWER_UNLOCK_KEY 14'h210C
`define RCPM_ADDR_LOWPOWER_CLOCK_SELECT 14'h2110
`define RCPM_ADDR_LOWPOWER_BLOCK_POWERDOWN 14'h2114
`define RCPM_ADDR_SYS_STATUS 14'h2120
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RCPM_RST_POWER_MODE_CTRL 16'h0001
`define RCPM_RST_LOWPOWER_BLOCK_POWERDOWN 32'h00000102
// ----------------------------------------
// Field positions
// ----------------------------------------
`define RCPM_BIT_POR_FLAG 0
`define RCPM_BIT_PIN_FLAG 1
`define RCPM_BIT_RSVD_FLAG 2
`define RCPM_BIT_SOFT_FLAG 3
`define RCPM_BIT_TIMER_SLEEP 2
`define RCPM_BIT_SEQ_SLEEP 3
`define RCPM_BIT_ADC_KEEP 14
`define RCPM_BIT_RAM_KEEP 15
`define RCPM_BIT_LF_SYSCLK 0
`define RCPM_BIT_HFOSC_PD 0
`define RCPM_BIT_HSREF_PD 1
`define RCPM_BIT_ALDO_PD 8
`define RCPM_LPCON_MASK 32'h000001CF
// ----------------------------------------
// Modes and keys
// ----------------------------------------
`define RCPM_MODE_ACTIVE 2'h1
`define RCPM_MODE_HIBERNATE 2'h2
`define RCPM_MODE_RESERVED 2'h3
`define RCPM_PWR_KEY_FIRST 16'h4859
`define RCPM_PWR_KEY_SECOND 16'hF27B
`define RCPM_LP_KEY 20'hC59D6
`define RCPM_SOFT_RESET_CODE 16'hA158
`endif

// ==== test/rcpm_ctrl_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module rcpm_ctrl_monitor #(
	parameter ADDR_W = 14
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic seq_wr,
	input wire logic seq_sleep_cmd,
	input wire logic timer_sleep_req,
	input wire logic soft_reset_req,
	input wire logic hs_clk_enable,
	input wire logic digital_core_power,
	input wire logic sram_power,
	input wire logic ram_keep_in_sleep,
	input wire logic lf_sysclk_allowed,
	input wire logic [31:0] lowpower_powerdown
);
	// ----------------------------------------
	// Port checks
	// ----------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	wire wr = psel && penable && pwrite;
	wire sleep_cause = wr && (paddr == 14'h0A00 || paddr == 14'h2114) || seq_sleep_cmd || timer_sleep_req;
	property p_rst_vals; $rose(nrst) |-> hs_clk_enable && !ram_keep_in_sleep && lowpower_powerdown == 32'h00000102; endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("reset levels wrong");
	property p_sta_rsvd; psel && penable && !pwrite && paddr == 14'h0A40 |-> prdata[31:4] == 0 && !prdata[2]; endproperty
	a_sta_rsvd: assert property (p_sta_rsvd) else $error("status reserved bits set");
	property p_soft_req; wr && paddr == 14'h0424 && pwdata[15:0] == 16'hA158 |=> soft_reset_req; endproperty
	a_soft_req: assert property (p_soft_req) else $error("soft reset pulse missing");
	property p_pwr_group; (!hs_clk_enable || digital_core_power) && (!digital_core_power || sram_power); endproperty
	a_pwr_group: assert property (p_pwr_group) else $error("power levels disagree");
	property p_sleep_cause; $fell(hs_clk_enable) |-> $past(sleep_cause) || $past(sleep_cause, 2); endproperty
	a_sleep_cause: assert property (p_sleep_cause) else $error("sleep without cause");
	property p_ram_keep; $changed(ram_keep_in_sleep) |-> $past(wr && paddr == 14'h0A00, 2); endproperty
	a_ram_keep: assert property (p_ram_keep) else $error("ram keep changed alone");
	property p_lf_cause; $changed(lf_sysclk_allowed) |-> $past(seq_wr || wr && paddr == 14'h2110, 2); endproperty
	a_lf_cause: assert property (p_lf_cause) else $error("clock select changed alone");
	property p_lpd_cause; $changed(lowpower_powerdown) |-> $past(wr && paddr == 14'h2114, 2); endproperty
	a_lpd_cause: assert property (p_lpd_cause) else $error("powerdown changed alone");
endmodule
bind rcpm_ctrl rcpm_ctrl_monitor #(.ADDR_W(ADDR_W)) rcpm_ctrl_monitor_i (.sys_clk(sys_clk), .nrst(nrst),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
	.seq_wr(seq_wr), .seq_sleep_cmd(seq_sleep_cmd), .timer_sleep_req(timer_sleep_req),
	.soft_reset_req(soft_reset_req), .hs_clk_enable(hs_clk_enable), .digital_core_power(digital_core_power),
	.sram_power(sram_power), .ram_keep_in_sleep(ram_keep_in_sleep), .lf_sysclk_allowed(lf_sysclk_allowed),
	.lowpower_powerdown(lowpower_powerdown));
`default_nettype wire

// ==== test/rcpm_ctrl_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module rcpm_ctrl_bench;
	logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, seq_wr = 0, er;
	logic [4:0] ev = 0;
	logic [13:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	wire [31:0] prdata, lowpower_powerdown;
	wire pready, pslverr, hs_clk_enable, digital_core_power, sram_power, ram_keep_in_sleep, adc_switch_on;
	wire lf_sysclk_allowed;
	int mismatches = 0, n_compared = 0, ku = 0, lk = 0, m_sta = 1, m_ctrl = 1, m_lpd = 'h102, m_lf = 0, v;
	always #5 sys_clk = ~sys_clk;
	rcpm_ctrl rcpm_ctrl_i (.sys_clk(sys_clk), .nrst(nrst), .por_event(ev[0]), .pin_reset_event(ev[1]),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .seq_wr(seq_wr), .seq_sleep_cmd(ev[2]), .timer_sleep_req(ev[3]),
		.wake_req(ev[4]), .soft_reset_req(), .hs_clk_enable(hs_clk_enable), .digital_core_power(digital_core_power),
		.sram_power(sram_power), .ram_keep_in_sleep(ram_keep_in_sleep), .adc_switch_on(adc_switch_on),
		.lf_sysclk_allowed(lf_sysclk_allowed), .lowpower_powerdown(lowpower_powerdown));
	// ----------------------------------------
	// Bus, model and comparison tasks
	// ----------------------------------------
	task report_and_stop;
		if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, s, e);
		end
	endtask
	task settle;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	task apb(input logic [13:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wr(input logic [13:0] a, input int d);
		apb(a, 1, d);
		if (a == 14'h0A40) m_sta &= ~d;
		if (a == 14'h0A00 && ku == 2) m_ctrl = d & 'hC00F;
		if (a == 14'h2114 && lk) m_lpd = d & 'h1CF;
		if (a == 14'h2110 && lk) m_lf = d & 1;
		if (a == 14'h210C) lk = (d & 'hFFFFF) == 'hC59D6;
		ku = a != 14'h0A04 ? 0 : d == 'h4859 ? 1 : (d == 'hF27B && ku == 1) ? 2 : 0;
	endtask
	task rdc(input logic [13:0] a, input int e);
		apb(a, 0, 0);
		chk(rd, e);
	endtask
	task kw(input int d);
		wr(14'h0A04, 'h4859);
		wr(14'h0A04, 'hF27B);
		wr(14'h0A00, d);
		settle;
	endtask
	task pulse(input int k);
		@(posedge sys_clk);
		ev <= 5'h1 << k;
		@(posedge sys_clk);
		ev <= 0;
		settle;
	endtask
	task pw(input logic e);
		chk({hs_clk_enable, digital_core_power}, {e & ~m_lpd[0], e});
		chk(sram_power, e | m_ctrl[15]);
	endtask
	task seqw(input int d);
		@(posedge sys_clk);
		paddr <= 14'h2110;
		pwdata <= d;
		seq_wr <= 1;
		@(posedge sys_clk);
		seq_wr <= 0;
		if (lk) m_lf = d;
		settle;
		chk(lf_sysclk_allowed, m_lf);
	endtask
	initial begin
		#100000;
		mismatches++;
		report_and_stop;
	end
	initial begin
		void'($urandom(32'h8d8caad0));
		repeat (12) @(posedge sys_clk);
		nrst <= 1;
		settle;
		pw(1);
		chk(lowpower_powerdown, m_lpd);
		rdc(14'h0A00, m_ctrl);
		for (int i = 0; i < 2; i++) begin
			pulse(i);
			m_sta |= 1 << i;
			rdc(14'h0A40, m_sta);
			wr(14'h0A40, 0);
			rdc(14'h0A40, m_sta);
			wr(14'h0A40, 1 << i);
			rdc(14'h0A40, m_sta);
		end
		wr(14'h0424, 'hA158);
		m_sta |= 8;
		rdc(14'h0A40, m_sta);
		wr(14'h0A40, 'hFFFF);
		rdc(14'h0A40, m_sta);
		wr(14'h0A00, 'h8002);
		rdc(14'h0A00, m_ctrl);
		wr(14'h0A04, 'h4859);
		wr(14'h0A40, 0);
		wr(14'h0A04, 'hF27B);
		wr(14'h0A00, 'h8002);
		rdc(14'h0A00, m_ctrl);
		v = ($urandom & 'hC00C) | 2;
		kw(v);
		pw(0);
		chk(ram_keep_in_sleep, v >> 15);
		chk(adc_switch_on, (v >> 14) & 1);
		rdc(14'h0A00, m_ctrl);
		kw(v | 3);
		pw(0);
		rdc(14'h0A00, m_ctrl);
		pulse(4);
		pw(1);
		for (int i = 0; i < 2; i++) begin
			kw(1);
			pulse(2 + i);
			pw(1);
			kw(1 | 8 >> i);
			pulse(2 + i);
			pw(0);
			pulse(4);
		end
		v = $urandom & 'h1CF;
		wr(14'h2114, v);
		rdc(14'h2114, m_lpd);
		wr(14'h210C, 'hC59D6);
		wr(14'h2114, v);
		rdc(14'h2114, m_lpd);
		chk(lowpower_powerdown, m_lpd);
		wr(14'h2110, 1);
		settle;
		chk(lf_sysclk_allowed, m_lf);
		seqw(0);
		wr(14'h210C, 5);
		seqw(1);
		apb(14'h0B00, 0, 0);
		chk(er, 1);
		chk(rd, 0);
		report_and_stop;
	end
endmodule
`default_nettype wire
